//--- rtl/mfr_top.sv
// Multi-line fast read command sequencer with burst wrap setting.
// Assumes the serial clock runs far slower than i_clk_sys, which
// samples it, and that the array answers reads in the same cycle.
`timescale 1ns/1ns
`include "mfr_cfg.svh"

// Operation
// - 3Ch always takes a 32-bit address.
// - 6Bh: serial address, eight dummies, quad data.
// - 6Ch always takes a 32-bit address.
// - BBh: address two per clock, four dummies.
// - BCh: 32-bit address two per clock.
// - EBh: quad address and data, six dummies.
// - EBh uses 32 bits in wide mode.
// - ECh: 32-bit quad address always.
// - Wrap setting applies to EBh reads.
// - Wrap setting applies to ECh reads.
// - Wrap inside aligned section until deselect.
// - 77h frame: code, dummies, setting byte.
// - Ignore top bit and low nibble.
// - Disable flag and length select decode.
// - Wrap setting kept until next 77h.
// - Reset forces wrap disabled.
// - 77h carries eight dummies in wide mode.
// - Sample rising, drive falling, MSB first.
// - Linear address increments per byte.
// - Reads ignored while array busy.
// - Short mode uses extended address byte.
module mfr_top #(
    parameter int FIFO_DEPTH = `MFR_FIFO_DEPTH
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_sw_reset,
    input wire logic i_spi_clk,
    input wire logic i_cs_n,
    input wire logic [3:0] i_io_in,
    output logic [3:0] o_io_out,
    output logic [3:0] o_io_oe,
    input wire logic i_addr4_mode,
    input wire logic [7:0] i_ext_addr,
    input wire logic i_busy,
    output logic [31:0] o_rd_addr,
    output logic o_rd_req,
    input wire logic [7:0] i_rd_data,
    input wire logic i_rd_valid,
    output logic o_rd_ready,
    output logic o_wrap_disable_flag,
    output logic [1:0] o_wrap_length_select,
    output logic o_cmd_active
);

    // =================================================================
    // Helper functions
    // =================================================================
    // Maps a command code to its phase shape.
    function automatic mfr_pkg::mfr_cmd_s decode(input logic [7:0] c);
        mfr_pkg::mfr_cmd_s d;
        d = '0;
        d.valid = 1'b1;
        d.is_read = 1'b1;
        unique case (c)
            `MFR_CMD_DOR, `MFR_CMD_DOR4:
            begin
                d.addr_lanes = `MFR_LANE_1;
                d.data_lanes = `MFR_LANE_2;
                d.dummy = `MFR_DUMMY_OUT;
                d.force32 = (c == `MFR_CMD_DOR4);
            end
            `MFR_CMD_QOR, `MFR_CMD_QOR4:
            begin
                d.addr_lanes = `MFR_LANE_1;
                d.data_lanes = `MFR_LANE_4;
                d.dummy = `MFR_DUMMY_OUT;
                d.force32 = (c == `MFR_CMD_QOR4);
            end
            `MFR_CMD_DIO, `MFR_CMD_DIO4:
            begin
                d.addr_lanes = `MFR_LANE_2;
                d.data_lanes = `MFR_LANE_2;
                d.dummy = `MFR_DUMMY_DIO;
                d.force32 = (c == `MFR_CMD_DIO4);
            end
            `MFR_CMD_QIO, `MFR_CMD_QIO4:
            begin
                d.addr_lanes = `MFR_LANE_4;
                d.data_lanes = `MFR_LANE_4;
                d.dummy = `MFR_DUMMY_QIO;
                d.force32 = (c == `MFR_CMD_QIO4);
                d.wrap_ok = 1'b1;
            end
            `MFR_CMD_WRAP:
            begin
                d.is_read = 1'b0;
                d.is_wrap = 1'b1;
                d.addr_lanes = `MFR_LANE_4;
            end
            default:
            begin
                d.valid = 1'b0;
                d.is_read = 1'b0;
            end
        endcase
        return d;
    endfunction : decode

    // Shifts one clock's worth of input bits in, MSB first.
    function automatic logic [31:0] shift_in(input logic [31:0] sh,
        input logic [3:0] io, input logic [2:0] lanes);
        if (lanes == `MFR_LANE_1)
        begin
            return {sh[30:0], io[0]};
        end
        else if (lanes == `MFR_LANE_2)
        begin
            return {sh[29:0], io[1:0]};
        end
        return {sh[27:0], io};
    endfunction : shift_in

    // Next array address, either linear or inside the wrap section.
    function automatic logic [31:0] next_addr(input logic [31:0] a,
        input logic wrap, input logic [1:0] sel);
        logic [31:0] m;
        m = (`MFR_WRAP_BASE_LEN << sel) - 32'h0000_0001;
        if (wrap)
        begin
            return (a & ~m) | ((a + 32'h0000_0001) & m);
        end
        return a + 32'h0000_0001;
    endfunction : next_addr

    // Top lanes of a byte placed on the IO lines.
    function automatic logic [3:0] top_bits(input logic [7:0] b,
        input logic [2:0] lanes);
        if (lanes == `MFR_LANE_2)
        begin
            return {2'h0, b[7:6]};
        end
        return b[7:4];
    endfunction : top_bits

    // =================================================================
    // Pin synchronisers and edge detection
    // =================================================================
    logic [5:0] sync1_r; // First stage, read only by the second.
    logic [5:0] sync2_r; // Stable copy of {cs_n, sclk, io}.
    logic sclk_d_r; // Delayed stable serial clock.
    logic cs_hi; // Chip select deasserted.
    logic sclk_rise;
    logic sclk_fall;
    logic [3:0] io_s;

    // Two flops per pin; chip select resets high so nothing starts.
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sync1_r <= 6'h20;
            sync2_r <= 6'h20;
            sclk_d_r <= 1'b0;
        end
        else
        begin
            sync1_r <= {i_cs_n, i_spi_clk, i_io_in};
            sync2_r <= sync1_r;
            sclk_d_r <= sync2_r[4];
        end
    end

    assign cs_hi = sync2_r[5];
    assign io_s = sync2_r[3:0];
    assign sclk_rise = sync2_r[4] && !sclk_d_r && !cs_hi;
    assign sclk_fall = !sync2_r[4] && sclk_d_r && !cs_hi;

    // =================================================================
    // Command decoder
    // =================================================================
    mfr_pkg::mfr_state_e state_r; // Current phase.
    mfr_pkg::mfr_cmd_s cmd_r; // Shape of the active command.
    mfr_pkg::mfr_cmd_s dec; // Decode of the code being completed.
    logic [7:0] cmd_sh_r; // Command bits collected so far.
    logic [31:0] addr_sh_r; // Address or dummy bits collected.
    logic [5:0] cnt_r; // Rising edges within the current phase.
    logic [5:0] addr_clks_r; // Clocks the address phase lasts.
    logic [3:0] wnib_r; // First nibble of the wrap setting byte.
    logic wide; // Full 32-bit address expected.
    logic addr_last; // Last address clock of a read.
    logic [31:0] addr_next; // Address register with the current bits.
    logic [31:0] addr_full; // Assembled start address.

    assign dec = decode({cmd_sh_r[6:0], io_s[0]});
    assign wide = dec.force32 || i_addr4_mode;
    assign addr_last = (state_r == mfr_pkg::MFR_ADDR) && sclk_rise &&
                       (cnt_r == addr_clks_r - 6'h01) && !cmd_r.is_wrap;
    assign addr_next = shift_in(addr_sh_r, io_s, cmd_r.addr_lanes);
    assign addr_full = (cmd_r.force32 || i_addr4_mode) ? addr_next :
        {i_ext_addr, addr_next[23:0]};

    // Phase sequencing on stable serial clock rising edges.
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_r <= mfr_pkg::MFR_IDLE;
            cmd_r <= '0;
            cmd_sh_r <= 8'h00;
            addr_sh_r <= 32'h0000_0000;
            cnt_r <= 6'h00;
            addr_clks_r <= 6'h00;
            wnib_r <= 4'h0;
        end
        else if (cs_hi)
        begin
            state_r <= mfr_pkg::MFR_IDLE;
            cnt_r <= 6'h00;
        end
        else if (sclk_rise)
        begin
            unique case (state_r)
                // command in, MSB first on the first line.
                mfr_pkg::MFR_IDLE:
                begin
                    cmd_sh_r <= {cmd_sh_r[6:0], io_s[0]};
                    cnt_r <= cnt_r + 6'h01;
                    if (cnt_r == 6'h07)
                    begin
                        cnt_r <= 6'h00;
                        cmd_r <= dec;
                        // Address clocks: bits divided by lane count.
                        addr_clks_r <= (wide ? `MFR_ADDR_BITS_WIDE :
                            `MFR_ADDR_BITS_SHORT) >> (dec.addr_lanes >> 1);
                        if (!dec.valid || (dec.is_read && i_busy))
                        begin
                            state_r <= mfr_pkg::MFR_IGNORE;
                        end
                        else
                        begin
                            state_r <= mfr_pkg::MFR_ADDR;
                        end
                    end
                end
                mfr_pkg::MFR_ADDR:
                begin
                    addr_sh_r <= shift_in(addr_sh_r, io_s,
                                          cmd_r.addr_lanes);
                    cnt_r <= cnt_r + 6'h01;
                    if (cnt_r == addr_clks_r - 6'h01)
                    begin
                        cnt_r <= 6'h00;
                        state_r <= cmd_r.is_wrap ?
                            mfr_pkg::MFR_WRAPSET : mfr_pkg::MFR_DUMMY;
                    end
                end
                mfr_pkg::MFR_DUMMY:
                begin
                    cnt_r <= cnt_r + 6'h01;
                    if (cnt_r == cmd_r.dummy - 6'h01)
                    begin
                        cnt_r <= 6'h00;
                        state_r <= mfr_pkg::MFR_DATA;
                    end
                end
                // Setting byte arrives as two quad nibbles.
                mfr_pkg::MFR_WRAPSET:
                begin
                    wnib_r <= io_s;
                    cnt_r <= cnt_r + 6'h01;
                    if (cnt_r == 6'h01)
                    begin
                        state_r <= mfr_pkg::MFR_IGNORE;
                    end
                end
                // Data and ignored frames last until deselect.
                mfr_pkg::MFR_DATA, mfr_pkg::MFR_IGNORE:
                begin
                    cnt_r <= cnt_r;
                end
            endcase
        end
    end

    assign o_cmd_active = (state_r != mfr_pkg::MFR_IDLE);

    // =================================================================
    // Wrap configuration
    // =================================================================
    logic wrap_dis_r; // Wrap disable flag.
    logic [1:0] wrap_len_r; // Section length select.

    // Stored only when the whole byte arrived; a short frame is void.
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wrap_dis_r <= `MFR_WRAP_DIS_RST;
            wrap_len_r <= `MFR_WRAP_LEN_RST;
        end
        else if (i_sw_reset)
        begin
            wrap_dis_r <= `MFR_WRAP_DIS_RST;
            wrap_len_r <= `MFR_WRAP_LEN_RST;
        end
        else if (state_r == mfr_pkg::MFR_WRAPSET && sclk_rise &&
                 cnt_r == 6'h01)
        begin
            wrap_dis_r <= wnib_r[`MFR_WRAP_DIS_BIT];
            wrap_len_r <= wnib_r[`MFR_WRAP_LEN_HI:`MFR_WRAP_LEN_LO];
        end
    end

    assign o_wrap_disable_flag = wrap_dis_r;
    assign o_wrap_length_select = wrap_len_r;

    // =================================================================
    // Array prefetch into the buffer
    // =================================================================
    logic fetch_on_r; // Prefetch running for this frame.
    logic [31:0] fa_r; // Next array address to fetch.
    logic wrap_use_r; // This frame wraps.
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic pop;

    // Fetching starts during the dummy clocks to hide array latency.
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            fetch_on_r <= 1'b0;
            fa_r <= 32'h0000_0000;
            wrap_use_r <= 1'b0;
        end
        else if (cs_hi)
        begin
            fetch_on_r <= 1'b0;
        end
        else if (addr_last)
        begin
            fetch_on_r <= 1'b1;
            fa_r <= addr_full;
            wrap_use_r <= cmd_r.wrap_ok && !wrap_dis_r;
        end
        else if (fetch_on_r && i_rd_valid && fifo_in_ready)
        begin
            fa_r <= next_addr(fa_r, wrap_use_r, wrap_len_r);
        end
    end

    assign o_rd_addr = fa_r;
    assign o_rd_req = fetch_on_r;
    assign o_rd_ready = fetch_on_r && fifo_in_ready;

    mfr_fifo #(
        .W(`MFR_BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_flush(cs_hi),
        .i_in_valid(fetch_on_r && i_rd_valid),
        .o_in_ready(fifo_in_ready),
        .i_in_data(i_rd_data),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(pop),
        .o_out_data(fifo_out_data)
    );

    // =================================================================
    // Output shifter
    // =================================================================
    logic [7:0] sh_r; // Remaining bits of the byte on the wire.
    logic [3:0] bits_r; // Bits still to send from sh_r.
    logic [3:0] out_r;
    logic [3:0] oe_r;
    logic [7:0] byte_now;

    assign pop = (state_r == mfr_pkg::MFR_DATA) && sclk_fall &&
                 (bits_r == 4'h0) && fifo_out_valid;
    // An underrun sends all ones rather than stale data.
    assign byte_now = fifo_out_valid ? fifo_out_data : 8'hFF;

    // Data changes on falling edges, MSB first.
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sh_r <= 8'h00;
            bits_r <= 4'h0;
            out_r <= 4'h0;
            oe_r <= 4'h0;
        end
        else if (cs_hi)
        begin
            bits_r <= 4'h0;
            out_r <= 4'h0;
            oe_r <= 4'h0;
        end
        else if (state_r == mfr_pkg::MFR_DATA && sclk_fall)
        begin
            oe_r <= (cmd_r.data_lanes == `MFR_LANE_2) ? 4'h3 : 4'hF;
            if (bits_r == 4'h0)
            begin
                out_r <= top_bits(byte_now, cmd_r.data_lanes);
                sh_r <= byte_now << cmd_r.data_lanes;
                bits_r <= 4'h8 - {1'b0, cmd_r.data_lanes};
            end
            else
            begin
                out_r <= top_bits(sh_r, cmd_r.data_lanes);
                sh_r <= sh_r << cmd_r.data_lanes;
                bits_r <= bits_r - {1'b0, cmd_r.data_lanes};
            end
        end
    end

    assign o_io_out = out_r;
    assign o_io_oe = oe_r;

endmodule : mfr_top

//--- rtl/mfr_cfg.svh
// Constants for the multi-line fast read and burst wrap block.
// Assumes inclusion by bare name from files under rtl/.
`ifndef MFR_CFG_SVH
`define MFR_CFG_SVH

// =====================================================================
// Command codes
// =====================================================================
`define MFR_CMD_DOR 8'h3B
`define MFR_CMD_DOR4 8'h3C
`define MFR_CMD_QOR 8'h6B
`define MFR_CMD_QOR4 8'h6C
`define MFR_CMD_DIO 8'hBB
`define MFR_CMD_DIO4 8'hBC
`define MFR_CMD_QIO 8'hEB
`define MFR_CMD_QIO4 8'hEC
`define MFR_CMD_WRAP 8'h77

// =====================================================================
// Lane counts and dummy clock counts
// =====================================================================
`define MFR_LANE_1 3'h1
`define MFR_LANE_2 3'h2
`define MFR_LANE_4 3'h4
`define MFR_DUMMY_OUT 6'h08
`define MFR_DUMMY_DIO 6'h04
`define MFR_DUMMY_QIO 6'h06
`define MFR_ADDR_BITS_SHORT 6'h18
`define MFR_ADDR_BITS_WIDE 6'h20

// =====================================================================
// Wrap setting byte fields and reset values
// =====================================================================
`define MFR_WRAP_DIS_BIT 0
`define MFR_WRAP_LEN_HI 2
`define MFR_WRAP_LEN_LO 1
`define MFR_WRAP_DIS_RST 1'b1
`define MFR_WRAP_LEN_RST 2'h0
`define MFR_WRAP_BASE_LEN 32'h0000_0008

// =====================================================================
// Buffer sizing
// =====================================================================
`define MFR_FIFO_DEPTH 32
`define MFR_BYTE_W 8

`endif

//--- rtl/mfr_pkg.sv
// Types used by the fast read block; its buffer uses none of them.
// Assumes mfr_cfg.svh supplies all numeric constants.
package mfr_pkg;

    // =================================================================
    // Command phase states
    // =================================================================
    typedef enum logic [2:0]
    {
        MFR_IDLE,
        MFR_ADDR,
        MFR_DUMMY,
        MFR_DATA,
        MFR_WRAPSET,
        MFR_IGNORE
    } mfr_state_e;

    // Decoded properties of one command code.
    typedef struct packed
    {
        logic valid;
        logic is_read;
        logic is_wrap;
        logic force32;
        logic wrap_ok;
        logic [2:0] addr_lanes;
        logic [2:0] data_lanes;
        logic [5:0] dummy;
    } mfr_cmd_s;

endpackage : mfr_pkg

//--- rtl/mfr_fifo.sv
// Byte buffer between the array read port and the serial shifter.
// Assumes one clock domain; flush empties it in a single cycle.
`timescale 1ns/1ns
module mfr_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 32
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_flush,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [W-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [W-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    // Storage words and pointers carrying one extra wrap bit.
    logic [W-1:0] mem_r [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    logic full;
    logic empty;

    // =================================================================
    // Flags
    // =================================================================
    // Full when pointers differ only in the wrap bit.
    assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                  (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    assign empty = (wr_ptr_r == rd_ptr_r);
    assign o_in_ready = !full;
    assign o_out_valid = !empty;
    assign o_out_data = mem_r[rd_ptr_r[AW-1:0]];

    // Write side; flush drops anything arriving in the same cycle.
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_ptr_r <= '0;
        end
        else if (i_flush)
        begin
            wr_ptr_r <= '0;
        end
        else if (i_in_valid && !full)
        begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
        end
    end

    // Storage array is not reset; only the pointers define content.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_in_valid && !full && !i_flush)
        begin
            mem_r[wr_ptr_r[AW-1:0]] <= i_in_data;
        end
    end

    // Read side.
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rd_ptr_r <= '0;
        end
        else if (i_flush)
        begin
            rd_ptr_r <= '0;
        end
        else if (i_out_ready && !empty)
        begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
        end
    end

endmodule : mfr_fifo

//--- testbench/mfr_top_monitor.sv
// Port-level checks for the fast read block.
// Assumes it is bound into mfr_top and sees only that module's ports.
`timescale 1ns/1ns
module mfr_top_monitor #(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_sw_reset,
    input wire logic i_cs_n,
    input wire logic [3:0] o_io_oe,
    input wire logic i_rd_valid,
    input wire logic [31:0] o_rd_addr,
    input wire logic o_rd_req,
    input wire logic o_rd_ready,
    input wire logic o_wrap_disable_flag,
    input wire logic [1:0] o_wrap_length_select,
    input wire logic o_cmd_active
);
    // ==================================================================
    // Clocking and sequences
    // ==================================================================
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);
    // Chip select seen high long enough to pass the synchronisers.
    sequence s_desel;
        i_cs_n [*5];
    endsequence
    // One array byte taken while reads run linearly.
    sequence s_fetch;
        i_rd_valid && o_rd_ready && o_wrap_disable_flag;
    endsequence
    // ==================================================================
    // Assertions
    // ==================================================================
    AST_OE_CODE: assert property (o_io_oe inside {4'h0, 4'h3, 4'hF})
        else $error("drive enable pattern not dual or quad");
    AST_DESEL_IDLE: assert property (s_desel |-> o_io_oe == 4'h0
        && !o_cmd_active && !o_rd_req) else $error("drive after deselect");
    AST_OE_ACTIVE: assert property (o_io_oe != 4'h0
        |-> o_cmd_active || $past(o_cmd_active)) else $error("idle drive");
    AST_REQ_ACTIVE: assert property (o_rd_req
        |-> o_cmd_active || $past(o_cmd_active)) else $error("idle fetch");
    AST_READY_REQ: assert property (o_rd_ready |-> o_rd_req)
        else $error("ready without fetch");
    AST_LINEAR_STEP: assert property (s_fetch ##1 o_rd_req
        |-> o_rd_addr == $past(o_rd_addr) + 32'h1) else $error("no step");
    AST_SWRST_WRAP: assert property (i_sw_reset |=> o_wrap_disable_flag
        && o_wrap_length_select == 2'h0) else $error("wrap not reset");
    AST_WRAP_HOLD: assert property (!$stable({o_wrap_disable_flag,
        o_wrap_length_select}) |-> $past(i_sw_reset) || $past(o_cmd_active))
        else $error("wrap setting changed outside a frame");
endmodule : mfr_top_monitor

bind mfr_top mfr_top_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) u_mon (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_sw_reset(i_sw_reset),
    .i_cs_n(i_cs_n), .o_io_oe(o_io_oe), .i_rd_valid(i_rd_valid),
    .o_rd_addr(o_rd_addr), .o_rd_req(o_rd_req), .o_rd_ready(o_rd_ready),
    .o_wrap_disable_flag(o_wrap_disable_flag),
    .o_wrap_length_select(o_wrap_length_select), .o_cmd_active(o_cmd_active)
);

//--- testbench/mfr_host.sv
// Behavioural host controller driving the serial link in mode 0.
// Assumes an 80 ns link clock that stands low outside frames.
`timescale 1ns/1ns
module mfr_host (
    output logic o_spi_clk,
    output logic o_cs_n,
    output logic [3:0] o_io_wire,
    input wire logic [3:0] i_io_out,
    input wire logic [3:0] i_io_oe
);
    logic [3:0] drv = 4'h0; // Levels the host puts on its lanes.
    logic [3:0] hoe = 4'h0; // Lanes the host drives.
    logic [3:0] last = 4'h0; // Last wire level, used when nobody drives.
    initial
    begin
        o_spi_clk = 1'b0;
        o_cs_n = 1'b1;
    end
    // ==================================================================
    // Wire resolution
    // ==================================================================
    // A floating lane shows the inverse of its last level, so a stale
    // value can never pass for device data.
    always_comb
        for (int k = 0; k < 4; k++)
            o_io_wire[k] = i_io_oe[k] ? i_io_out[k] :
                hoe[k] ? drv[k] : ~last[k];
    // Select or deselect; the 3 ns offset keeps edges off the sys clock.
    task automatic sel(input bit lo);
        #43;
        o_cs_n = !lo;
        hoe = 4'h0;
        #80;
    endtask : sel
    task automatic xfer(input logic [31:0] v, input int n, input int ln,
                        input bit d, output logic [31:0] r);
        r = 32'h0;
        for (int c = 0; c < n; c++)
        begin
            hoe = d ? (4'h1 << ln) - 4'h1 : 4'h0;
            drv = v[31:28] >> (4 - ln);
            v = v << ln;
            #40;
            r = (r << ln) | 32'(o_io_wire & ((4'h1 << ln) - 4'h1));
            last = o_io_wire;
            o_spi_clk = 1'b1;
            #40;
            o_spi_clk = 1'b0;
        end
    endtask : xfer
endmodule : mfr_host

//--- testbench/testbench.sv
// Self-checking bench for the fast read block and its wrap setting.
// Assumes mfr_host on the link and an array answering in one cycle.
`timescale 1ns/1ns
module testbench;
    logic clk, rst_n, sw, a4, busy, rvalid, sclk, cs_n, stall;
    logic rd_req, rd_ready, wdis, act;
    logic [7:0] ext, rdat;
    logic [3:0] iow, io_out, oe;
    logic [1:0] wlen;
    logic [31:0] rd_addr, r;
    int fail_count = 0;
    int checks = 0;
    logic [7:0] cmds [8] = '{8'h3B, 8'h3C, 8'h6B, 8'h6C,
                             8'hBB, 8'hBC, 8'hEB, 8'hEC};
    int al_t [8] = '{1, 1, 1, 1, 2, 2, 4, 4};
    int dl_t [8] = '{2, 2, 4, 4, 2, 2, 4, 4};
    int dm_t [8] = '{8, 8, 8, 8, 4, 4, 6, 6};
    // Array content is a fixed function of the byte address.
    assign rdat = rd_addr[7:0] ^ rd_addr[31:24] ^ 8'h5A;
    always @(posedge clk) rvalid <= !(stall && rvalid); // Stall halves it.
    mfr_top #(.FIFO_DEPTH(32)) uut (.i_clk_sys(clk), .i_rst_n(rst_n),
        .i_sw_reset(sw), .i_spi_clk(sclk), .i_cs_n(cs_n), .i_io_in(iow),
        .o_io_out(io_out), .o_io_oe(oe), .i_addr4_mode(a4),
        .i_ext_addr(ext), .i_busy(busy), .o_rd_addr(rd_addr),
        .o_rd_req(rd_req), .i_rd_data(rdat), .i_rd_valid(rvalid),
        .o_rd_ready(rd_ready), .o_wrap_disable_flag(wdis),
        .o_wrap_length_select(wlen), .o_cmd_active(act));
    mfr_host host (.o_spi_clk(sclk), .o_cs_n(cs_n), .o_io_wire(iow),
        .i_io_out(io_out), .i_io_oe(oe));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] e, s);
        checks++;
        if (s !== e)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    // Read frame; wl is the expected section length, 0 when linear.
    task automatic rd(input logic [7:0] c, input bit m4, input int al,
        input int dl, dm, input logic [31:0] a, input int n, wl);
        logic [31:0] ea;
        int aw;
        aw = (m4 || !c[0]) ? 32 : 24;
        @(posedge clk) a4 <= m4;
        host.sel(1);
        host.xfer({c, 24'h0}, 8, 1, 1, r);
        host.xfer(aw == 32 ? a : a << 8, aw / al, al, 1, r);
        host.xfer(32'h0, dm, 4, 0, r); // lines released
        if (dm == 8)
            chk("buffer full", 32'h0, 32'(rd_ready));
        if (aw == 24)
            a[31:24] = ext;
        for (int i = 0; i < n; i++)
        begin
            host.xfer(32'h0, 8 / dl, dl, 0, r);
            ea = wl ? (a & ~(wl - 1)) | ((a + i) & (wl - 1)) : a + i;
            chk("read byte", {24'h0, ea[7:0] ^ ea[31:24] ^ 8'h5A}, r);
        end
        host.sel(0);
        chk("idle drive", 32'h0, {28'h0, oe});
    endtask : rd
    task automatic wrap_set(input bit m4, input logic [7:0] w);
        @(posedge clk) a4 <= m4;
        host.sel(1);
        host.xfer({8'h77, 24'h0}, 8, 1, 1, r);
        host.xfer(32'h0, m4 ? 8 : 6, 4, 1, r);
        host.xfer({w, 24'h0}, 2, 4, 1, r);
        host.sel(0);
    endtask : wrap_set
    initial
    begin
        {rst_n, sw, a4, busy, stall} = 5'h00;
        ext = 8'h3C;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("wrap default", 32'h4, {29'h0, wdis, wlen});
        for (int m = 0; m < 2; m++)
            for (int k = 0; k < 8; k++)
                rd(cmds[k], m[0], al_t[k], dl_t[k], dm_t[k],
                   32'hA1B2_C3F0 + k, 3, 0);
        wrap_set(0, 8'hAF);
        chk("wrap set", 32'h1, {29'h0, wdis, wlen});
        ext <= 8'hC5;
        rd(8'hEB, 0, 4, 4, 6, 32'h0000_001E, 4, 16);
        stall <= 1'b1;
        rd(8'hEC, 1, 4, 4, 6, 32'h1234_567C, 6, 16);
        stall <= 1'b0;
        rd(8'h6B, 0, 1, 4, 8, 32'h0000_001E, 3, 0);
        wrap_set(1, 8'h70);
        chk("wrap off", 32'h7, {29'h0, wdis, wlen});
        wrap_set(0, 8'h60);
        @(posedge clk) sw <= 1'b1;
        @(posedge clk) sw <= 1'b0;
        @(posedge clk);
        chk("sw reset", 32'h4, {29'h0, wdis, wlen});
        busy <= 1'b1;
        host.sel(1);
        host.xfer({8'hEB, 24'h0}, 8, 1, 1, r);
        host.xfer(32'h0, 16, 4, 0, r);
        chk("busy drive", 32'h0, {27'h0, rd_req, oe});
        host.sel(0);
        busy <= 1'b0;
        close_out();
    end
    // Watchdog: a hang counts as a mismatch.
    initial
    begin
        #900000;
        fail_count++;
        close_out();
    end
endmodule : testbench
